// File: bench/host_model.sv
`timescale 1ns/1ps

module host_model
   import pwm_pkg::*;
(
   input  wire logic        core_clk,
   output logic      [7:0]  addr,
   output logic      [31:0] wr_data,
   output logic             wr_strobe,
   output logic             rd_strobe,
   input  wire logic [31:0] rd_data_q
);
   initial begin
      addr      = 8'h00;
      wr_data   = 32'h0;
      wr_strobe = 1'b0;
      rd_strobe = 1'b0;
   end

   // Idle lines show the inverse so stale values never look valid
   task automatic write_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      addr      <= a;
      wr_data   <= d;
      wr_strobe <= 1'b1;
      @(posedge core_clk);
      wr_strobe <= 1'b0;
      addr      <= ~a;
      wr_data   <= ~d;
   endtask

   task automatic read_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge core_clk);
      addr      <= a;
      rd_strobe <= 1'b1;
      @(posedge core_clk);
      rd_strobe <= 1'b0;
      addr      <= ~a;
      #1;
      d = rd_data_q;
   endtask

   // All four values and the enable go out as one packet
   task automatic send_packet(input logic [15:0] f, input logic [15:0] m,
                              input logic [15:0] t, input logic [15:0] r, input logic en);
      write_reg(REG_CMD_FSW, {16'h0, f});
      write_reg(REG_CMD_DEPTH, {16'h0, m});
      write_reg(REG_CMD_DEAD, {16'h0, t});
      write_reg(REG_CMD_FREF, {16'h0, r});
      write_reg(REG_CMD_SEND, {31'h0, en});
   endtask
endmodule

// File: bench/pwm_chk.sv
`timescale 1ns/1ps

module pwm_chk
   import pwm_pkg::*;
#(
   parameter int UPDATE_PERIOD = UPDATE_CYCLES
)
(
   input wire logic        core_clk,
   input wire logic        reset,
   input wire logic [7:0]  addr,
   input wire logic        rd_strobe,
   input wire logic [31:0] rd_data_q,
   input wire logic [2:0]  high_side_gate,
   input wire logic [2:0]  low_side_gate,
   input wire logic        report_strobe_q
);
   // ------
   // Report spacing
   // ------
   logic [31:0] gap_q;
   logic        seen_q;

   always_ff @(posedge core_clk) begin
      if (reset) begin
         gap_q  <= 32'h0;
         seen_q <= 1'b0;
      end else begin
         gap_q  <= report_strobe_q ? 32'h1 : gap_q + 32'h1;
         seen_q <= seen_q | report_strobe_q;
      end
   end

   // ------
   // Properties
   // ------
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);

   a_legs_exclusive: assert property ((high_side_gate & low_side_gate) == 3'h0)
      else $error("both gates of one leg on");
   a_dead_low_high: assert property ($fell(low_side_gate[0]) |-> !high_side_gate[0] [*3])
      else $error("high side on too soon");
   a_dead_high_low: assert property ($fell(high_side_gate[1]) |-> !low_side_gate[1] [*3])
      else $error("low side on too soon");
   a_quiet_after_reset: assert property ($fell(reset) |->
      ((high_side_gate | low_side_gate) == 3'h0 && !report_strobe_q) [*8])
      else $error("activity right after reset");
   a_report_pulse: assert property (report_strobe_q |=> !report_strobe_q)
      else $error("report strobe too long");
   a_report_period: assert property (report_strobe_q && seen_q |-> gap_q == UPDATE_PERIOD)
      else $error("report spacing wrong");
   a_read_idle: assert property (!$past(rd_strobe) |-> rd_data_q == 32'h0)
      else $error("read data without read");
   a_read_unmapped: assert property (rd_strobe && addr > REG_RPT_TEMP |=> rd_data_q == 32'h0)
      else $error("unmapped read not zero");
   a_read_upper: assert property (rd_data_q[31:16] == 16'h0)
      else $error("upper read bits set");

   c_report: cover property (report_strobe_q);
   c_gate_on: cover property ($rose(high_side_gate[2]));
   c_unmapped: cover property (rd_strobe && addr > REG_RPT_TEMP);
endmodule

bind three_phase_sine_pwm_ctrl pwm_chk #(.UPDATE_PERIOD(UPDATE_PERIOD)) u_chk (
   .core_clk        (core_clk),
   .reset           (reset),
   .addr            (addr),
   .rd_strobe       (rd_strobe),
   .rd_data_q       (rd_data_q),
   .high_side_gate  (high_side_gate),
   .low_side_gate   (low_side_gate),
   .report_strobe_q (report_strobe_q)
);

// File: bench/tb.sv
`timescale 1ns/1ps

module tb;
   import pwm_pkg::*;
   localparam int UP = 200;
   localparam logic [15:0] PK [4][4] = '{'{FSW_MAX, DEPTH_MAX, DEAD_MAX, FREF_MAX},
      '{FSW_MIN, DEPTH_MIN, DEAD_MIN, FREF_MIN}, '{16'h0000, 16'h03e9, 16'h0063, 16'h01f5},
      '{16'h0065, 16'h01f4, 16'h07d1, 16'h00fa}};
   localparam logic [15:0] EX [4][4] = '{'{FSW_MAX, DEPTH_MAX, DEAD_MAX, FREF_MAX},
      '{FSW_MIN, DEPTH_MIN, DEAD_MIN, FREF_MIN}, '{FSW_MIN, DEPTH_MIN, DEAD_MIN, FREF_MIN},
      '{FSW_MIN, 16'h01f4, DEAD_MIN, 16'h00fa}};
   localparam logic [15:0] DF [4] = '{FSW_RST, DEPTH_RST, DEAD_RST, FREF_RST};

   logic        core_clk = 1'b0;
   logic        reset = 1'b1;
   logic [7:0]  addr;
   logic [31:0] wr_data;
   logic        wr_strobe;
   logic        rd_strobe;
   logic [31:0] rd_data_q;
   logic [15:0] bus_voltage = 16'h0190;
   logic [15:0] temperature = 16'h0016;
   logic [2:0]  high_side_gate;
   logic [2:0]  low_side_gate;
   logic        report_strobe_q;
   logic [31:0] rd;
   int          miscompares = 0;
   int          checks_done = 0;
   int          cycles = 0;
   int          waited = 0;

   always #20 core_clk = ~core_clk;

   host_model u_host (.core_clk(core_clk), .addr(addr), .wr_data(wr_data),
      .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rd_data_q(rd_data_q));

   three_phase_sine_pwm_ctrl #(.UPDATE_PERIOD(UP)) u_dut (.core_clk(core_clk), .reset(reset),
      .addr(addr), .wr_data(wr_data), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe),
      .rd_data_q(rd_data_q), .bus_voltage(bus_voltage), .temperature(temperature),
      .high_side_gate(high_side_gate), .low_side_gate(low_side_gate),
      .report_strobe_q(report_strobe_q));

   // ------
   // Common tasks
   // ------
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      u_host.read_reg(a, rd);
      chk_word(rd, exp);
   endtask

   task automatic wait_report;
      waited = 0;
      @(posedge core_clk);
      #1;
      while (report_strobe_q !== 1'b1 && waited < 2 * UP) begin
         @(posedge core_clk);
         #1;
         waited++;
      end
      chk_word({31'h0, report_strobe_q}, 32'h1);
   endtask

   // Two reports, since a send in the tick cycle waits a whole period
   task automatic apply(input int i, input logic en);
      u_host.send_packet(PK[i][0], PK[i][1], PK[i][2], PK[i][3], en);
      wait_report();
      wait_report();
   endtask

   // Rising edges of all six gates seen over n cycles
   task automatic watch(input int n, output logic [5:0] m);
      logic [5:0] p;
      p = {high_side_gate, low_side_gate};
      m = 6'h0;
      repeat (n) begin
         @(posedge core_clk);
         #1;
         m = m | ({high_side_gate, low_side_gate} & ~p);
         p = {high_side_gate, low_side_gate};
      end
   endtask

   // ------
   // Scenarios
   // ------
   task automatic t_defaults;
      for (int i = 0; i < 4; i++)
         rd_chk(8'(4 * i), {16'h0, DF[i]});
      wait_report();
      for (int i = 0; i < 4; i++)
         rd_chk(REG_RPT_FSW + 8'(4 * i), {16'h0, DF[i]});
      rd_chk(REG_RPT_STATUS, 32'h0);
      rd_chk(REG_RPT_VBUS, 32'h0190);
      rd_chk(REG_RPT_TEMP, 32'h0016);
      rd_chk(8'h30, 32'h0);
      chk_word({26'h0, high_side_gate, low_side_gate}, 32'h0);
   endtask

   task automatic t_limits;
      for (int p = 0; p < 4; p++) begin
         apply(p, 1'b0);
         for (int i = 0; i < 4; i++)
            rd_chk(REG_RPT_FSW + 8'(4 * i), {16'h0, EX[p][i]});
         rd_chk(REG_RPT_STATUS, (p > 1) ? 32'h4 : 32'h0);
      end
      u_host.write_reg(REG_RPT_FSW, 32'h0033);
      rd_chk(REG_RPT_FSW, {16'h0, FSW_MIN});
   endtask

   task automatic t_enable;
      logic [5:0] m;
      bus_voltage <= 16'h0320;
      temperature <= 16'h0026;
      u_host.send_packet(FSW_MAX, 16'h01f4, DEAD_MIN, FREF_MAX, 1'b1);
      wait_report();
      wait_report();
      rd_chk(REG_RPT_STATUS, 32'h1);
      rd_chk(REG_CMD_SEND, 32'h1);
      rd_chk(REG_RPT_VBUS, 32'h0320);
      rd_chk(REG_RPT_TEMP, 32'h0026);
      watch(600, m);
      chk_word({26'h0, m}, 32'h3f);
      apply(0, 1'b0);
      watch(100, m);
      chk_word({20'h0, m, high_side_gate, low_side_gate}, 32'h0);
   endtask

   task automatic t_period;
      wait_report();
      wait_report();
      chk_word(32'(waited + 1), 32'(UP));
   endtask

   // ------
   // Run control
   // ------
   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Ceiling well above about 4000 cycles of planned traffic
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         complete_run();
      end
   end

   initial begin
      repeat (8) @(posedge core_clk);
      reset <= 1'b0;
      t_defaults();
      t_limits();
      t_enable();
      t_period();
      complete_run();
   end
endmodule

// File: hdl/gate_leg.sv
`timescale 1ns/1ps

module gate_leg
   import pwm_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       reset,
   input  wire logic       enable,
   input  wire logic       raw_high,
   input  wire logic [5:0] dead_cycles,
   output logic            high_side_q,
   output logic            low_side_q
);

   leg_state_t state_q;
   logic       side_q;
   logic [5:0] count_q;

   // ------------------------------------------------------------
   // Dead-time sequencer
   // ------------------------------------------------------------
   // Every change of side passes through a gap with both switches off
   always_ff @(posedge core_clk) begin
      if (reset || !enable) begin
         state_q <= LEG_OFF;
         side_q  <= 1'b0;
         count_q <= 6'h00;
      end else begin
         case (state_q)
            LEG_OFF: begin
               side_q  <= raw_high;
               count_q <= dead_cycles;
               state_q <= LEG_DEAD;
            end
            LEG_DEAD: begin
               if (raw_high != side_q) begin
                  side_q  <= raw_high;
                  count_q <= dead_cycles;
               end else if (count_q <= 6'h01) begin
                  state_q <= LEG_ON;
               end else begin
                  count_q <= count_q - 6'h01;
               end
            end
            LEG_ON: begin
               if (raw_high != side_q) begin
                  side_q  <= raw_high;
                  count_q <= dead_cycles;
                  state_q <= LEG_DEAD;
               end
            end
            default: state_q <= LEG_OFF;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Gate drive
   // ------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (reset || !enable) begin
         high_side_q <= 1'b0;
         low_side_q  <= 1'b0;
      end else begin
         // Both sides off unless settled; never both on
         high_side_q <= (state_q == LEG_ON) && side_q && (raw_high == side_q);
         low_side_q  <= (state_q == LEG_ON) && !side_q && (raw_high == side_q);
      end
   end

endmodule

// File: hdl/three_phase_sine_pwm_ctrl.sv
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps

// Overview of operation
// - Three legs of open-loop PWM from sine reference compared with a triangle carrier.
// - Carrier frequency in kHz, 1 to 100, 20 after reset.
// - Depth times 1000, 0 to 1000, 10 after reset.
// - Dead time in ns between high and low gates, 100 to 2000, 300 default.
// - Reference frequency in Hz, 1 to 500, 300 after reset.
// - One enable gates all six outputs; disabled after reset.
// - Every report carries the applied values and enable state.
// - Every report also carries bus voltage and temperature readings.
// - Packets decoded and reports sent about once per second.
module three_phase_sine_pwm_ctrl
   import pwm_pkg::*;
#(
   parameter int UPDATE_PERIOD = UPDATE_CYCLES
)
(
   input  wire logic        core_clk,
   input  wire logic        reset,
   input  wire logic [7:0]  addr,
   input  wire logic [31:0] wr_data,
   input  wire logic        wr_strobe,
   input  wire logic        rd_strobe,
   output logic      [31:0] rd_data_q,
   input  wire logic [15:0] bus_voltage,
   input  wire logic [15:0] temperature,
   output logic      [2:0]  high_side_gate,
   output logic      [2:0]  low_side_gate,
   output logic             report_strobe_q
);

   // ------------------------------------------------------------
   // Command staging and packet latch
   // ------------------------------------------------------------
   logic [15:0] stage_fsw_q;
   logic [15:0] stage_depth_q;
   logic [15:0] stage_dead_q;
   logic [15:0] stage_fref_q;
   logic [15:0] pkt_fsw_q;
   logic [15:0] pkt_depth_q;
   logic [15:0] pkt_dead_q;
   logic [15:0] pkt_fref_q;
   logic        pkt_en_q;
   logic        pending_q;

   always_ff @(posedge core_clk) begin
      if (reset) begin
         stage_fsw_q   <= FSW_RST;
         stage_depth_q <= DEPTH_RST;
         stage_dead_q  <= DEAD_RST;
         stage_fref_q  <= FREF_RST;
      end else if (wr_strobe) begin
         if (addr == REG_CMD_FSW) begin
            stage_fsw_q <= wr_data[15:0];
         end
         if (addr == REG_CMD_DEPTH) begin
            stage_depth_q <= wr_data[15:0];
         end
         if (addr == REG_CMD_DEAD) begin
            stage_dead_q <= wr_data[15:0];
         end
         if (addr == REG_CMD_FREF) begin
            stage_fref_q <= wr_data[15:0];
         end
      end
   end

   // Send captures all five fields at once so a decode never sees a mix
   always_ff @(posedge core_clk) begin
      if (reset) begin
         pkt_fsw_q   <= FSW_RST;
         pkt_depth_q <= DEPTH_RST;
         pkt_dead_q  <= DEAD_RST;
         pkt_fref_q  <= FREF_RST;
         pkt_en_q    <= 1'b0;
      end else if (wr_strobe && addr == REG_CMD_SEND) begin
         pkt_fsw_q   <= stage_fsw_q;
         pkt_depth_q <= stage_depth_q;
         pkt_dead_q  <= stage_dead_q;
         pkt_fref_q  <= stage_fref_q;
         pkt_en_q    <= wr_data[SEND_EN_BIT];
      end
   end

   // ------------------------------------------------------------
   // Update interval
   // ------------------------------------------------------------
   logic [31:0] tick_cnt_q;
   logic        tick;

   assign tick = (tick_cnt_q == 32'(UPDATE_PERIOD - 1));

   always_ff @(posedge core_clk) begin
      if (reset || tick) begin
         tick_cnt_q <= 32'h0000_0000;
      end else begin
         tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
      end
   end

   // A send in the decode cycle stays pending for the next decode
   always_ff @(posedge core_clk) begin
      if (reset) begin
         pending_q <= 1'b0;
      end else if (wr_strobe && addr == REG_CMD_SEND) begin
         pending_q <= 1'b1;
      end else if (tick) begin
         pending_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Decode with range checks
   // ------------------------------------------------------------
   logic [15:0] fsw_q;
   logic [15:0] depth_q;
   logic [15:0] dead_q;
   logic [15:0] fref_q;
   logic        enable_q;
   logic        reject_q;
   logic        fsw_ok;
   logic        depth_ok;
   logic        dead_ok;
   logic        fref_ok;
   logic        apply;

   assign fsw_ok   = (pkt_fsw_q >= FSW_MIN) && (pkt_fsw_q <= FSW_MAX);
   assign depth_ok = (pkt_depth_q >= DEPTH_MIN) && (pkt_depth_q <= DEPTH_MAX);
   assign dead_ok  = (pkt_dead_q >= DEAD_MIN) && (pkt_dead_q <= DEAD_MAX);
   assign fref_ok  = (pkt_fref_q >= FREF_MIN) && (pkt_fref_q <= FREF_MAX);
   assign apply    = tick && pending_q;

   always_ff @(posedge core_clk) begin
      if (reset) begin
         fsw_q    <= FSW_RST;
         depth_q  <= DEPTH_RST;
         dead_q   <= DEAD_RST;
         fref_q   <= FREF_RST;
         enable_q <= 1'b0;
         reject_q <= 1'b0;
      end else if (apply) begin
         // Each bad field keeps its old value; the good ones still apply
         if (fsw_ok) begin
            fsw_q <= pkt_fsw_q;
         end
         if (depth_ok) begin
            depth_q <= pkt_depth_q;
         end
         if (dead_ok) begin
            dead_q <= pkt_dead_q;
         end
         if (fref_ok) begin
            fref_q <= pkt_fref_q;
         end
         enable_q <= pkt_en_q;
         reject_q <= !(fsw_ok && depth_ok && dead_ok && fref_ok);
      end
   end

   // ------------------------------------------------------------
   // Report snapshot, one cycle after decode
   // ------------------------------------------------------------
   logic        snap_q;
   logic [15:0] rpt_fsw_q;
   logic [15:0] rpt_depth_q;
   logic [15:0] rpt_dead_q;
   logic [15:0] rpt_fref_q;
   logic [15:0] rpt_vbus_q;
   logic [15:0] rpt_temp_q;
   logic [2:0]  rpt_status_q;

   always_ff @(posedge core_clk) begin
      if (reset) begin
         snap_q          <= 1'b0;
         report_strobe_q <= 1'b0;
      end else begin
         snap_q          <= tick;
         report_strobe_q <= snap_q;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         rpt_fsw_q    <= FSW_RST;
         rpt_depth_q  <= DEPTH_RST;
         rpt_dead_q   <= DEAD_RST;
         rpt_fref_q   <= FREF_RST;
         rpt_vbus_q   <= 16'h0000;
         rpt_temp_q   <= 16'h0000;
         rpt_status_q <= 3'h0;
      end else if (snap_q) begin
         rpt_fsw_q    <= fsw_q;
         rpt_depth_q  <= depth_q;
         rpt_dead_q   <= dead_q;
         rpt_fref_q   <= fref_q;
         rpt_status_q <= {reject_q, pending_q, enable_q};
         rpt_vbus_q   <= bus_voltage;
         rpt_temp_q   <= temperature;
      end
   end

   // ------------------------------------------------------------
   // Register read port
   // ------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (reset || !rd_strobe) begin
         rd_data_q <= 32'h0000_0000;
      end else begin
         case (addr)
            REG_CMD_FSW:    rd_data_q <= {16'h0000, stage_fsw_q};
            REG_CMD_DEPTH:  rd_data_q <= {16'h0000, stage_depth_q};
            REG_CMD_DEAD:   rd_data_q <= {16'h0000, stage_dead_q};
            REG_CMD_FREF:   rd_data_q <= {16'h0000, stage_fref_q};
            REG_CMD_SEND:   rd_data_q <= {31'h0000_0000, pkt_en_q};
            REG_RPT_FSW:    rd_data_q <= {16'h0000, rpt_fsw_q};
            REG_RPT_DEPTH:  rd_data_q <= {16'h0000, rpt_depth_q};
            REG_RPT_DEAD:   rd_data_q <= {16'h0000, rpt_dead_q};
            REG_RPT_FREF:   rd_data_q <= {16'h0000, rpt_fref_q};
            REG_RPT_STATUS: rd_data_q <= {29'h0000_0000, rpt_status_q};
            REG_RPT_VBUS:   rd_data_q <= {16'h0000, rpt_vbus_q};
            REG_RPT_TEMP:   rd_data_q <= {16'h0000, rpt_temp_q};
            default:        rd_data_q <= 32'h0000_0000;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Carrier and reference phase
   // ------------------------------------------------------------
   logic [23:0]        carr_q;
   logic [31:0]        ref_q;
   logic [10:0]        tri_wave;
   logic signed [27:0] carrier_val;
   logic [5:0]         dead_cyc_q;
   logic [31:0]        dead_prod;

   always_ff @(posedge core_clk) begin
      if (reset) begin
         carr_q <= 24'h00_0000;
         ref_q  <= 32'h0000_0000;
      end else begin
         carr_q <= carr_q + 24'(fsw_q) * 24'(CARRIER_STEP_PER_KHZ);
         ref_q  <= ref_q + 32'(fref_q) * 32'(REF_STEP_PER_HZ);
      end
   end

   // Symmetric triangle: fold the upper half of the phase
   assign tri_wave    = carr_q[23] ? ~carr_q[22:12] : carr_q[22:12];
   assign carrier_val = 28'($signed({1'b0, tri_wave}) - CARRIER_MID) * 28'(CARRIER_SCALE);

   // ns to cycles by reciprocal multiply, rounded up; avoids a divider
   assign dead_prod = (32'(dead_q) + 32'(DEAD_ROUNDUP)) * 32'(DEAD_RECIP);

   always_ff @(posedge core_clk) begin
      if (reset) begin
         dead_cyc_q <= 6'h08;
      end else begin
         dead_cyc_q <= dead_prod[21:16];
      end
   end

   // ------------------------------------------------------------
   // Per-leg reference, comparison and gates
   // ------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : g_leg
         logic [15:0]        phase;
         logic [30:0]        para;
         logic signed [16:0] sine;
         logic signed [27:0] ref_q_leg;
         logic               raw_q;

         assign phase = ref_q[31:16] + PHASE_OFS[g];
         // Parabolic half-wave: cheap sine shape without a table
         assign para  = {1'b0, phase[14:0]} * (16'h8000 - {1'b0, phase[14:0]});
         assign sine  = phase[15] ? -$signed({1'b0, para[30:15]})
                                  : $signed({1'b0, para[30:15]});

         always_ff @(posedge core_clk) begin
            if (reset) begin
               ref_q_leg <= 28'sh000_0000;
               raw_q     <= 1'b0;
            end else begin
               ref_q_leg <= 28'(sine) * 28'($signed({1'b0, depth_q[10:0]}));
               raw_q     <= ref_q_leg > carrier_val;
            end
         end

         gate_leg u_leg (
            .core_clk    (core_clk),
            .reset       (reset),
            .enable      (enable_q),
            .raw_high    (raw_q),
            .dead_cycles (dead_cyc_q),
            .high_side_q (high_side_gate[g]),
            .low_side_q  (low_side_gate[g])
         );
      end
   endgenerate

endmodule

// File: pkg/pwm_pkg.sv
package pwm_pkg;

   // ------------------------------------------------------------
   // Clock and timing
   // ------------------------------------------------------------
   localparam int CLK_HZ         = 25_000_000;
   localparam int CLK_NS         = 1_000_000_000 / CLK_HZ;
   localparam int UPDATE_TIME_MS = 1000;
   localparam int UPDATE_CYCLES  = UPDATE_TIME_MS * (CLK_HZ / 1000);

   // Per-unit phase steps, rounded to nearest
   localparam logic [15:0] CARRIER_STEP_PER_KHZ =
      16'((64'd16777216 * 64'd1000 + 64'(CLK_HZ / 2)) / 64'(CLK_HZ));
   localparam logic [15:0] REF_STEP_PER_HZ =
      16'((64'd4294967296 + 64'(CLK_HZ / 2)) / 64'(CLK_HZ));
   // Reciprocal of the clock period in ns, scaled by 2^16, rounded up
   localparam logic [15:0] DEAD_RECIP   = 16'((65536 + CLK_NS - 1) / CLK_NS);
   localparam logic [15:0] DEAD_ROUNDUP = 16'(CLK_NS - 1);

   // Carrier centre and scale so that full carrier equals full depth
   localparam logic signed [11:0] CARRIER_MID   = 12'sd1024;
   localparam logic signed [15:0] CARRIER_SCALE = 16'sd8000;

   // Reference phase offsets of the three legs (0, 120, 240 degrees)
   localparam logic [15:0] PHASE_OFS [3] = '{16'h0000, 16'h5555, 16'haaab};

   // ------------------------------------------------------------
   // Parameter limits and values after reset
   // ------------------------------------------------------------
   localparam logic [15:0] FSW_MIN     = 16'h0001;
   localparam logic [15:0] FSW_MAX     = 16'h0064;
   localparam logic [15:0] FSW_RST     = 16'h0014;
   localparam logic [15:0] DEPTH_MIN   = 16'h0000;
   localparam logic [15:0] DEPTH_MAX   = 16'h03e8;
   localparam logic [15:0] DEPTH_RST   = 16'h000a;
   localparam logic [15:0] DEAD_MIN    = 16'h0064;
   localparam logic [15:0] DEAD_MAX    = 16'h07d0;
   localparam logic [15:0] DEAD_RST    = 16'h012c;
   localparam logic [15:0] FREF_MIN    = 16'h0001;
   localparam logic [15:0] FREF_MAX    = 16'h01f4;
   localparam logic [15:0] FREF_RST    = 16'h012c;

   // ------------------------------------------------------------
   // Register offsets and control bits
   // ------------------------------------------------------------
   localparam logic [7:0] REG_CMD_FSW    = 8'h00;
   localparam logic [7:0] REG_CMD_DEPTH  = 8'h04;
   localparam logic [7:0] REG_CMD_DEAD   = 8'h08;
   localparam logic [7:0] REG_CMD_FREF   = 8'h0c;
   localparam logic [7:0] REG_CMD_SEND   = 8'h10;
   localparam logic [7:0] REG_RPT_FSW    = 8'h14;
   localparam logic [7:0] REG_RPT_DEPTH  = 8'h18;
   localparam logic [7:0] REG_RPT_DEAD   = 8'h1c;
   localparam logic [7:0] REG_RPT_FREF   = 8'h20;
   localparam logic [7:0] REG_RPT_STATUS = 8'h24;
   localparam logic [7:0] REG_RPT_VBUS   = 8'h28;
   localparam logic [7:0] REG_RPT_TEMP   = 8'h2c;

   localparam int SEND_EN_BIT     = 0;
   localparam int STAT_EN_BIT     = 0;
   localparam int STAT_PEND_BIT   = 1;
   localparam int STAT_REJECT_BIT = 2;

   // ------------------------------------------------------------
   // Gate leg states
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      LEG_OFF  = 3'b001,
      LEG_DEAD = 3'b010,
      LEG_ON   = 3'b100
   } leg_state_t;

endpackage
